// ### wes_pkg.sv
// Purpose: constants for the wake enable and management-interrupt status slice
// Assumes: byte registers on a classic Wishbone slave, one aligned word each
// Notes: offsets are register indices; byte address is four times the index
package wes_pkg;
  // ---------------------------------------------------------------
  // register indices
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_WAKE_EN4 = 8'h0D;
  localparam logic [7:0] IDX_WAKE_EN5 = 8'h0E;
  localparam logic [7:0] IDX_RSVD_0F = 8'h0F;
  localparam logic [7:0] IDX_SMI_UNITS = 8'h10;
  localparam logic [7:0] IDX_SMI_INDEV = 8'h11;
  localparam logic [7:0] IDX_SMI_PINS_A = 8'h12;
  localparam logic [7:0] IDX_SMI_PINS_B = 8'h13;
  localparam logic [7:0] IDX_SMI_FANS = 8'h14;
  localparam logic [7:0] IDX_RSVD_15 = 8'h15;
  // own registers
  localparam logic [7:0] IDX_WAKE_STS4 = 8'h20;
  localparam logic [7:0] IDX_WAKE_STS5 = 8'h21;
  localparam logic [7:0] IDX_SMI_EN1 = 8'h22;
  localparam logic [7:0] IDX_SMI_EN2 = 8'h23;
  localparam logic [7:0] IDX_SMI_EN3 = 8'h24;
  localparam logic [7:0] IDX_SMI_EN4 = 8'h25;
  localparam logic [7:0] IDX_SMI_EN5 = 8'h26;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h28;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h29;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'h2A;
  // ---------------------------------------------------------------
  // reset values and masks
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_SMI_UNITS = 8'h02;
  localparam logic [7:0] MASK_SMI_UNITS = 8'h3E;
  localparam logic [7:0] MASK_SMI_INDEV = 8'h17;
  localparam logic [7:0] MASK_SMI_PINS_A = 8'hF7;
  localparam logic [7:0] MASK_SMI_FANS = 8'hCF;
  localparam logic [7:0] MASK_ALL = 8'hFF;
  localparam int BIT_PRINTER = 1;
  localparam int BIT_INFRARED = 2;
  localparam int IRQ_BIT_WAKE = 0;
  localparam int IRQ_BIT_SMI = 1;
  localparam int IRQ_BIT_IR = 2;
  localparam int IRQ_WIDTH = 3;
endpackage : wes_pkg

// ### wes_wake_smi.sv
// Purpose: wake enable gating and management-interrupt status collection
// Assumes: Wishbone classic slave, 25 MHz clk_sys, all pin inputs asynchronous
// Notes: reset_n stands for the standby-supply power-on reset
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module wes_wake_smi
  import wes_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic [15:0] wakeSrc,
  input wire logic globalWakeEnable,
  input wire logic parallelPortActive,
  input wire logic printerAcknowledge_n,
  input wire logic [4:0] unitIrq,
  input wire logic mouseIrq,
  input wire logic keyboardIrq,
  input wire logic kbcOutputLine,
  input wire logic infraredRxPrimary,
  input wire logic infraredRxAlternate,
  input wire logic infraredSelAlternate,
  input wire logic [7:0] pinsA,
  input wire logic [7:0] pinsB,
  input wire logic [3:0] pinsFan,
  input wire logic fanSpeedEventA,
  input wire logic fanSpeedEventB,
  output logic wakeEventOut_n,
  output logic wakeEventOutEn,
  output logic groupMgmtIrq_n,
  output logic irqOut
);

  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  localparam int NSYNC = 52;
  logic [NSYNC-1:0] rawIn;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  assign rawIn = {wakeSrc, globalWakeEnable, parallelPortActive, printerAcknowledge_n,
                  unitIrq, mouseIrq, keyboardIrq, kbcOutputLine, infraredRxPrimary,
                  infraredRxAlternate, infraredSelAlternate, pinsA, pinsB, pinsFan,
                  fanSpeedEventA, fanSpeedEventB};

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else if (clkEn)
    begin
      sync1_q <= rawIn;
      sync2_q <= sync1_q;
    end
  end

  logic [15:0] sWake;
  logic sGlobal, sActive, sAck_n, sMouse, sKbd, sKbc, sIrP, sIrA, sIrSel, sFanA, sFanB;
  logic [4:0] sUnit;
  logic [7:0] sPinsA, sPinsB;
  logic [3:0] sPinsFan;
  // global enable and activate taken as clk_sys-sampled levels
  assign {sWake, sGlobal, sActive, sAck_n, sUnit, sMouse, sKbd, sKbc, sIrP, sIrA, sIrSel,
          sPinsA, sPinsB, sPinsFan, sFanA, sFanB} = sync2_q;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic req;
  logic wrStb;
  logic rdStb;
  logic [7:0] wrByte;
  logic hit;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign wrStb = req && wb_we_i && wb_sel_i[0] && hit;
  assign rdStb = req && !wb_we_i && hit;
  assign wrByte = wb_dat_i[7:0];

  function automatic logic isWr(input logic [7:0] idx);
    isWr = wrStb && (wb_adr_i == {idx[5:0], 2'b00});
  endfunction : isWr

  function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] setv,
                                     input logic clr, input logic [7:0] mask);
    // a new event wins over a clear in the same cycle
    w1c = ((cur & ~(clr ? wrByte : 8'h00)) | setv) & mask;
  endfunction : w1c

  // ---------------------------------------------------------------
  // wake enables and wake status
  // ---------------------------------------------------------------
  logic [7:0] wakeEn4_q;
  logic [7:0] wakeEn5_q;
  logic [7:0] wakeSts4_q;
  logic [7:0] wakeSts5_q;
  logic [15:0] wakePrev_q;
  logic [15:0] wakeRise;
  assign wakeRise = sWake & ~wakePrev_q;

  // only the standby reset reaches these
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wakeEn4_q <= RST_ZERO;
      wakeEn5_q <= RST_ZERO;
    end
    else if (clkEn)
    begin
      if (isWr(IDX_WAKE_EN4))
        wakeEn4_q <= wrByte;
      if (isWr(IDX_WAKE_EN5))
        wakeEn5_q <= wrByte;
    end
  end

  // status records every source regardless of its enable
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wakePrev_q <= '0;
      wakeSts4_q <= RST_ZERO;
      wakeSts5_q <= RST_ZERO;
    end
    else if (clkEn)
    begin
      wakePrev_q <= sWake;
      wakeSts4_q <= w1c(wakeSts4_q, wakeRise[7:0], isWr(IDX_WAKE_STS4), MASK_ALL);
      wakeSts5_q <= w1c(wakeSts5_q, wakeRise[15:8], isWr(IDX_WAKE_STS5), MASK_ALL);
    end
  end

  logic wakeAct;
  assign wakeAct = sGlobal && (|(wakeEn4_q & wakeSts4_q) || |(wakeEn5_q & wakeSts5_q));

  // open drain: drive low only while active
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      wakeEventOutEn <= 1'b0;
    else if (clkEn)
      wakeEventOutEn <= wakeAct;
  end
  assign wakeEventOut_n = 1'b0;

  // ---------------------------------------------------------------
  // management-interrupt status
  // ---------------------------------------------------------------
  logic [7:0] smiUnits;
  logic [7:0] smiIndev;
  logic irActive_q;
  logic irPrevLevel_q;
  logic irLevel;
  logic [7:0] smiPinsA_q, smiPinsB_q, smiFans_q;
  logic [7:0] pinsAPrev_q, pinsBPrev_q;
  logic [5:0] fanPrev_q;
  logic [5:0] fanNow;
  logic printerBit;

  // level bits that clear at their source, except the read-to-clear infrared bit
  // the bit tracks the acknowledge pin level, idle high like the pin
  assign printerBit = sActive ? sAck_n : 1'b1;
  assign smiUnits = {2'b00, sUnit[4:1], printerBit, 1'b0} & MASK_SMI_UNITS;
  assign smiIndev = {3'b000, sKbc, 1'b0, irActive_q, sKbd, sMouse} & MASK_SMI_INDEV;
  assign irLevel = sIrSel ? sIrA : sIrP;
  assign fanNow = {sFanB, sFanA, sPinsFan};

  // read-to-clear; a fresh edge during the read keeps the bit set
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irActive_q <= 1'b0;
      irPrevLevel_q <= 1'b0;
    end
    else if (clkEn)
    begin
      irPrevLevel_q <= irLevel;
      if (irLevel != irPrevLevel_q)
        irActive_q <= 1'b1;
      else if (rdStb && wb_adr_i == {IDX_SMI_INDEV[5:0], 2'b00})
        irActive_q <= 1'b0;
    end
  end

  logic [7:0] fanSet;
  assign fanSet = {fanNow[5:4], 2'b00, fanNow[3:0] & ~fanPrev_q[3:0]} &
                  {~fanPrev_q[5:4], 6'h3F};

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pinsAPrev_q <= '0;
      pinsBPrev_q <= '0;
      fanPrev_q <= '0;
      smiPinsA_q <= RST_ZERO;
      smiPinsB_q <= RST_ZERO;
      smiFans_q <= RST_ZERO;
    end
    else if (clkEn)
    begin
      pinsAPrev_q <= sPinsA;
      pinsBPrev_q <= sPinsB;
      fanPrev_q <= fanNow;
      smiPinsA_q <= w1c(smiPinsA_q, sPinsA & ~pinsAPrev_q, isWr(IDX_SMI_PINS_A),
                        MASK_SMI_PINS_A);
      smiPinsB_q <= w1c(smiPinsB_q, sPinsB & ~pinsBPrev_q, isWr(IDX_SMI_PINS_B),
                        MASK_ALL);
      smiFans_q <= w1c(smiFans_q, fanSet, isWr(IDX_SMI_FANS), MASK_SMI_FANS);
    end
  end

  // ---------------------------------------------------------------
  // management-interrupt enables and group output
  // ---------------------------------------------------------------
  logic [7:0] smiEn_q [5];
  logic [7:0] smiSrc [5];
  assign smiSrc[0] = smiUnits;
  assign smiSrc[1] = smiIndev;
  assign smiSrc[2] = smiPinsA_q;
  assign smiSrc[3] = smiPinsB_q;
  assign smiSrc[4] = smiFans_q;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 5; i++)
        smiEn_q[i] <= RST_ZERO;
    end
    else if (clkEn)
    begin
      for (int i = 0; i < 5; i++)
        if (isWr(IDX_SMI_EN1 + 8'(i)))
          smiEn_q[i] <= wrByte;
    end
  end

  logic smiAct;
  always_comb
  begin
    smiAct = 1'b0;
    for (int i = 0; i < 5; i++)
      smiAct = smiAct | (|(smiSrc[i] & smiEn_q[i]));
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      groupMgmtIrq_n <= 1'b1;
    else if (clkEn)
      groupMgmtIrq_n <= !smiAct;
  end

  // ---------------------------------------------------------------
  // block interrupt: sticky status, enable, write-one clear
  // ---------------------------------------------------------------
  logic [IRQ_WIDTH-1:0] irqSts_q;
  logic [IRQ_WIDTH-1:0] irqEn_q;
  logic [IRQ_WIDTH-1:0] irqEvt;
  logic wakeActPrev_q, smiActPrev_q, irPrevAct_q;
  assign irqEvt[IRQ_BIT_WAKE] = wakeAct && !wakeActPrev_q;
  assign irqEvt[IRQ_BIT_SMI] = smiAct && !smiActPrev_q;
  assign irqEvt[IRQ_BIT_IR] = irActive_q && !irPrevAct_q;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wakeActPrev_q <= 1'b0;
      smiActPrev_q <= 1'b0;
      irPrevAct_q <= 1'b0;
      irqSts_q <= '0;
      irqEn_q <= '0;
      irqOut <= 1'b0;
    end
    else if (clkEn)
    begin
      wakeActPrev_q <= wakeAct;
      smiActPrev_q <= smiAct;
      irPrevAct_q <= irActive_q;
      irqSts_q <= (irqSts_q & ~(isWr(IDX_IRQ_CLEAR) ? wrByte[IRQ_WIDTH-1:0] : '0)) | irqEvt;
      if (isWr(IDX_IRQ_ENABLE))
        irqEn_q <= wrByte[IRQ_WIDTH-1:0];
      irqOut <= |(irqSts_q & irqEn_q);
    end
  end

  // ---------------------------------------------------------------
  // read mux and acknowledge
  // ---------------------------------------------------------------
  logic [7:0] rdByte;
  always_comb
  begin
    hit = 1'b1;
    rdByte = 8'h00;
    unique case (wb_adr_i)
      {IDX_WAKE_EN4[5:0], 2'b00}: rdByte = wakeEn4_q;
      {IDX_WAKE_EN5[5:0], 2'b00}: rdByte = wakeEn5_q;
      {IDX_RSVD_0F[5:0], 2'b00}: rdByte = 8'h00;
      {IDX_SMI_UNITS[5:0], 2'b00}: rdByte = smiUnits;
      {IDX_SMI_INDEV[5:0], 2'b00}: rdByte = smiIndev;
      {IDX_SMI_PINS_A[5:0], 2'b00}: rdByte = smiPinsA_q;
      {IDX_SMI_PINS_B[5:0], 2'b00}: rdByte = smiPinsB_q;
      {IDX_SMI_FANS[5:0], 2'b00}: rdByte = smiFans_q;
      {IDX_RSVD_15[5:0], 2'b00}: rdByte = 8'h00;
      {IDX_WAKE_STS4[5:0], 2'b00}: rdByte = wakeSts4_q;
      {IDX_WAKE_STS5[5:0], 2'b00}: rdByte = wakeSts5_q;
      {IDX_SMI_EN1[5:0], 2'b00}: rdByte = smiEn_q[0];
      {IDX_SMI_EN2[5:0], 2'b00}: rdByte = smiEn_q[1];
      {IDX_SMI_EN3[5:0], 2'b00}: rdByte = smiEn_q[2];
      {IDX_SMI_EN4[5:0], 2'b00}: rdByte = smiEn_q[3];
      {IDX_SMI_EN5[5:0], 2'b00}: rdByte = smiEn_q[4];
      {IDX_IRQ_STATUS[5:0], 2'b00}: rdByte = {5'h00, irqSts_q};
      {IDX_IRQ_ENABLE[5:0], 2'b00}: rdByte = {5'h00, irqEn_q};
      {IDX_IRQ_CLEAR[5:0], 2'b00}: rdByte = 8'h00;
      default: hit = 1'b0;
    endcase
  end

  // one wait state: answer in the cycle after the request is seen
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else if (clkEn)
    begin
      wb_ack_o <= req && hit;
      wb_err_o <= req && !hit;
      if (req)
        wb_dat_o <= {24'h000000, hit ? rdByte : 8'h00};
    end
  end

endmodule : wes_wake_smi
`default_nettype wire

// ### wes_wake_smi_monitor.sv
// Purpose: port-level checks for the wake and management-interrupt slice
// Assumes: one clk_sys domain, reset_n active low
// Notes: byte address is four times the register index
`timescale 1ns/1ps
`default_nettype none
module wes_wake_smi_monitor
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic globalWakeEnable,
  input wire logic parallelPortActive,
  input wire logic [4:0] unitIrq,
  input wire logic wakeEventOut_n,
  input wire logic wakeEventOutEn,
  input wire logic groupMgmtIrq_n,
  input wire logic irqOut
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic rdAck;
  logic req;
  assign rdAck = wb_ack_o && !wb_we_i;
  assign req = wb_cyc_i && wb_stb_i && clkEn && !wb_ack_o && !wb_err_o;
  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  a_req_answered: assert property (req |=> wb_ack_o || wb_err_o)
    else $error("request not answered in one cycle");
  a_ack_one_cycle: assert property ($rose(wb_ack_o) |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_unmapped_err: assert property (req && wb_adr_i == 8'h00 |=> wb_err_o && !wb_ack_o)
    else $error("unmapped address not refused");
  a_reserved_zero: assert property (rdAck && (wb_adr_i == 8'h3C || wb_adr_i == 8'h54)
    |-> wb_dat_o == 32'h00000000) else $error("reserved register not zero");
  a_units_reserved: assert property (rdAck && wb_adr_i == 8'h40
    |-> wb_dat_o[0] == 1'b0 && wb_dat_o[7:6] == 2'h0) else $error("units reserved bit set");
  a_unit_levels: assert property ($stable(unitIrq)[*6] ##0 (rdAck && wb_adr_i == 8'h40)
    |-> wb_dat_o[5:2] == unitIrq[4:1]) else $error("unit bits not following sources");
  a_printer_idle: assert property (!parallelPortActive[*6] ##0 (rdAck && wb_adr_i == 8'h40)
    |-> wb_dat_o[1]) else $error("printer bit low while port inactive");
  a_indev_reserved: assert property (rdAck && wb_adr_i == 8'h44
    |-> wb_dat_o[3] == 1'b0 && wb_dat_o[7:5] == 3'h0) else $error("input reserved bit set");
  a_pins_reserved: assert property (rdAck
    |-> (wb_adr_i != 8'h48 || wb_dat_o[3] == 1'b0)
    && (wb_adr_i != 8'h50 || wb_dat_o[5:4] == 2'h0))
    else $error("pin reserved bit set");
  a_wake_global: assert property (!globalWakeEnable[*6] |=> !wakeEventOutEn)
    else $error("wake driven without global enable");
  a_wake_pin_low: assert property (wakeEventOutEn |-> !wakeEventOut_n)
    else $error("wake pin driven high");
  c_wake: cover property (wakeEventOutEn);
  c_group: cover property ($fell(groupMgmtIrq_n));
  c_irq: cover property (irqOut);
  c_err: cover property (wb_err_o);
endmodule : wes_wake_smi_monitor
bind wes_wake_smi wes_wake_smi_monitor mon (.clk_sys, .reset_n, .clkEn, .wb_adr_i, .wb_dat_o,
  .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o, .globalWakeEnable, .parallelPortActive,
  .unitIrq, .wakeEventOut_n, .wakeEventOutEn, .groupMgmtIrq_n, .irqOut);
`default_nettype wire

// ### wes_host_model.sv
// Purpose: host side of the shared wake line
// Assumes: open-drain wake line with a pull-up on the board
// Notes: resolves the line for the bench
`timescale 1ns/1ps
`default_nettype none
module wes_host_model
(
  input wire logic wakeEventOut_n,
  input wire logic wakeEventOutEn,
  output logic wakeWire
);
  // pull-up holds the line high whenever the slice lets go
  assign wakeWire = wakeEventOutEn ? wakeEventOut_n : 1'b1;
endmodule : wes_host_model
`default_nettype wire

// ### wes_wake_smi_tb.sv
// Purpose: self-checking bench for the wake and management-interrupt slice
// Assumes: 25 MHz clk_sys, Wishbone classic master in the bench
// Notes: input changes get six cycles to pass synchronisers and edge detect
`timescale 1ns/1ps
`default_nettype none
module wes_wake_smi_tb
  import wes_pkg::*;
;
  logic clk_sys, reset_n, clkEn, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o;
  logic [7:0] wb_adr_i, pinsA, pinsB;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [3:0] wb_sel_i, pinsFan;
  logic [15:0] wakeSrc;
  logic [4:0] unitIrq;
  logic globalWakeEnable, parallelPortActive, printerAcknowledge_n, mouseIrq, keyboardIrq;
  logic kbcOutputLine, infraredRxPrimary, infraredRxAlternate, infraredSelAlternate;
  logic fanSpeedEventA, fanSpeedEventB, wakeEventOut_n, wakeEventOutEn, groupMgmtIrq_n;
  logic irqOut, wakeWire;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  wes_wake_smi dut (.clk_sys, .reset_n, .clkEn, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
    .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o, .wakeSrc, .globalWakeEnable,
    .parallelPortActive, .printerAcknowledge_n, .unitIrq, .mouseIrq, .keyboardIrq,
    .kbcOutputLine, .infraredRxPrimary, .infraredRxAlternate, .infraredSelAlternate, .pinsA,
    .pinsB, .pinsFan, .fanSpeedEventA, .fanSpeedEventB, .wakeEventOut_n, .wakeEventOutEn,
    .groupMgmtIrq_n, .irqOut);
  wes_host_model host (.wakeEventOut_n, .wakeEventOutEn, .wakeWire);
  // -------------------------------------------------------------
  // bus and check helpers
  // -------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] wd,
    output logic [7:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_adr_i <= {idx[5:0], 2'b00};
    wb_we_i <= w;
    wb_dat_i <= {24'h000000, wd};
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 20)
      chk("bus answer", 8'h01, 8'h00);
    rd = wb_dat_o[7:0];
    er = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    bus(idx, 1'b1, d, r, e);
  endtask : wr
  task automatic rc(input string nm, input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] r;
    logic x;
    bus(idx, 1'b0, 8'h00, r, x);
    chk(nm, e, r);
  endtask : rc
  task automatic settle;
    repeat (6) @(posedge clk_sys);
  endtask : settle
  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic test_reset_map;
    logic [7:0] r;
    logic e;
    rc("wake en 4", 8'h0D, RST_ZERO);
    rc("wake en 5", 8'h0E, RST_ZERO);
    rc("units", 8'h10, RST_SMI_UNITS);
    rc("indev", 8'h11, RST_ZERO);
    rc("pins b", 8'h13, RST_ZERO);
    wr(8'h0F, 8'hFF);
    wr(8'h15, 8'hFF);
    rc("rsvd 0f", 8'h0F, RST_ZERO);
    rc("rsvd 15", 8'h15, RST_ZERO);
    bus(8'h00, 1'b0, 8'h00, r, e);
    chk("unmapped err", 8'h01, {7'h00, e});
    $display("test reset_map done");
  endtask : test_reset_map
  task automatic test_wake;
    wr(8'h0D, 8'hA5);
    wr(8'h0E, 8'h5A);
    rc("wake en 4", 8'h0D, 8'hA5);
    rc("wake en 5", 8'h0E, 8'h5A);
    wb_sel_i <= 4'h0;
    wr(8'h0D, 8'hFF);
    wb_sel_i <= 4'h1;
    rc("wake en no lane", 8'h0D, 8'hA5);
    @(posedge clk_sys);
    wakeSrc <= 16'h0202;
    settle;
    rc("wake sts 4", 8'h20, 8'h02);
    chk("line no global", 8'h01, {7'h00, wakeWire});
    globalWakeEnable <= 1'b1;
    settle;
    chk("line active", 8'h00, {7'h00, wakeWire});
    wr(8'h21, 8'h00);
    rc("sts 5 kept", 8'h21, 8'h02);
    wr(8'h21, 8'h02);
    settle;
    chk("line released", 8'h01, {7'h00, wakeWire});
    $display("test wake done");
  endtask : test_wake
  task automatic test_units;
    unitIrq <= 5'h1E;
    settle;
    rc("port idle", 8'h10, 8'h3E);
    parallelPortActive <= 1'b1;
    printerAcknowledge_n <= 1'b0;
    settle;
    rc("ack low", 8'h10, 8'h3C);
    unitIrq <= 5'h00;
    printerAcknowledge_n <= 1'b1;
    settle;
    rc("sources off", 8'h10, 8'h02);
    $display("test units done");
  endtask : test_units
  task automatic test_indev;
    {mouseIrq, keyboardIrq, kbcOutputLine} <= 3'h7;
    {infraredRxPrimary, infraredRxAlternate} <= 2'h3;
    settle;
    rc("indev set", 8'h11, 8'h17);
    rc("ir read clr", 8'h11, 8'h13);
    infraredSelAlternate <= 1'b1;
    infraredRxPrimary <= 1'b0;
    settle;
    rc("ir unselected", 8'h11, 8'h13);
    infraredRxAlternate <= 1'b0;
    settle;
    rc("ir alternate", 8'h11, 8'h17);
    {mouseIrq, keyboardIrq, kbcOutputLine} <= 3'h0;
    settle;
    rc("indev clear", 8'h11, 8'h00);
    $display("test indev done");
  endtask : test_indev
  task automatic test_pins_irq;
    wr(8'h2A, 8'h07);
    pinsA <= 8'hFF;
    pinsB <= 8'hFF;
    pinsFan <= 4'hF;
    {fanSpeedEventA, fanSpeedEventB} <= 2'h3;
    settle;
    rc("pins a", 8'h12, MASK_SMI_PINS_A);
    rc("pins b", 8'h13, 8'hFF);
    rc("fans", 8'h14, MASK_SMI_FANS);
    chk("group masked", 8'h01, {7'h00, groupMgmtIrq_n});
    wr(8'h24, 8'h01);
    settle;
    chk("group on", 8'h00, {7'h00, groupMgmtIrq_n});
    rc("irq sticky", 8'h28, 8'h02);
    chk("irq masked", 8'h00, {7'h00, irqOut});
    wr(8'h29, 8'h02);
    settle;
    chk("irq raised", 8'h01, {7'h00, irqOut});
    wr(8'h2A, 8'h02);
    settle;
    chk("irq cleared", 8'h00, {7'h00, irqOut});
    wr(8'h12, 8'h01);
    rc("pins a w1c", 8'h12, 8'hF6);
    wr(8'h13, 8'hFF);
    rc("pins b w1c", 8'h13, 8'h00);
    wr(8'h14, 8'hCF);
    rc("fans w1c", 8'h14, 8'h00);
    $display("test pins_irq done");
  endtask : test_pins_irq
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // -------------------------------------------------------------
  // sequence, clock and timeout
  // -------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial
  begin
    reset_n = 1'b0;
    clkEn = 1'b1;
    wb_sel_i = 4'h1;
    {wb_we_i, wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i} = '0;
    {wakeSrc, globalWakeEnable, parallelPortActive, unitIrq, pinsA, pinsB, pinsFan} = '0;
    {mouseIrq, keyboardIrq, kbcOutputLine, infraredSelAlternate} = '0;
    {infraredRxPrimary, infraredRxAlternate, fanSpeedEventA, fanSpeedEventB} = '0;
    printerAcknowledge_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    settle;
    test_reset_map;
    test_wake;
    test_units;
    test_indev;
    test_pins_irq;
    test_done;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      $display("MISMATCH run length expected 3000 seen more");
      test_done;
    end
  end
endmodule : wes_wake_smi_tb
`default_nettype wire
